/* File: addr_mode_pkg.sv */
// Constants and carrier types for the addressing input mode selector
// Contract
// - As a slave the input mode may switch only while the addressing channel is not yet locked.
// - Once the channel is active the mode in effect at activation is held until an IC reset.
// - The logic-level mode is entered after the input stays high longer than the qualification time.
// - The logic-level mode is left for current mode after the input stays low longer than the qualification time.
// - The qualification filter period lies between 7.68 ms and 8.192 ms of the internal clock.
// - At the end of initialization the initial mode follows the input level at that moment.
// - In master, repeater or monitor role the input is always treated as logic level.
// - In master role equal data inputs select a low-active stream that idles high.
// - In master role unequal data inputs select a high-active stream that idles low.
// - The channel activates only after four consecutive correct telegrams within the activation window.
package addr_mode_pkg;
    // Clock cycles per microsecond at 250 MHz
    localparam int unsigned CYCLES_PER_US = 250;
    // Qualification filter time in microseconds (7.680 ms)
    localparam int unsigned QUAL_TIME_US = 7680;
    // Filter length in clock cycles; kept in microseconds so the product fits 32 bits
    localparam int unsigned QUAL_CYCLES = QUAL_TIME_US * CYCLES_PER_US;
    localparam int unsigned QUAL_CNT_W = 21;

    // Role of the chip on the bus
    typedef enum logic [1:0] {ROLE_SLAVE, ROLE_MASTER, ROLE_REPEATER, ROLE_MONITOR} role_t;

    // Mode outputs carried together
    typedef struct packed {
        logic logic_mode;
        logic stream_low_active;
        logic locked;
    } mode_status_t;
endpackage

/* File: addr_mode_select.sv */
// Addressing input mode selector: current versus logic-level interpretation
`timescale 1ns/1ps
module addr_mode_select
    import addr_mode_pkg::*;
#(
    parameter int unsigned QUAL_COUNT = QUAL_CYCLES
)
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic addressing_input_in,
    input wire logic data_in_0_in,
    input wire logic data_in_1_in,
    input wire role_t role_in,
    input wire logic init_done_in,
    input wire logic channel_activate_in,
    output mode_status_t status_out
);
    // Sequencing: wait for initialization, filter, then freeze on lock
    typedef enum logic [1:0] {ST_INIT, ST_FILTER, ST_LOCKED} state_t;

    // Role test shared by the mode and polarity paths
    function automatic logic role_is_slave(input role_t role);
        return (role == ROLE_SLAVE);
    endfunction

    // Equal pins keep the legacy low-active stream
    function automatic logic pins_select_low(input logic pin_a, input logic pin_b);
        return (pin_a == pin_b);
    endfunction

    // Sequencer state
    state_t state_reg;
    state_t state_next;

    // Qualification timer
    logic [QUAL_CNT_W-1:0] qual_cnt_reg;
    logic [QUAL_CNT_W-1:0] qual_cnt_next;

    // Input level seen at the previous enabled edge
    logic last_level_reg;

    // Input mode chosen for slave operation, 1 = logic level
    logic slave_mode_reg;
    logic slave_mode_next;

    // Output flops
    mode_status_t status_reg;
    mode_status_t status_next;

    // Decoded conditions, named for the processes below
    wire logic is_slave;
    wire logic in_init;
    wire logic in_filter;
    wire logic level_changed;
    wire logic wants_switch;
    wire logic qual_expired;
    wire logic timer_clear;
    wire logic lock_request;
    wire logic switch_now;
    wire logic polarity_low;
    wire logic [QUAL_CNT_W-1:0] qual_limit;

    // Role and state decode
    assign is_slave = role_is_slave(role_in);
    assign in_init = (state_reg == ST_INIT);
    assign in_filter = (state_reg == ST_FILTER);

    // Level tracking; any change restarts the filter
    assign level_changed = (addressing_input_in != last_level_reg);
    // Only a level opposite to the current mode is worth qualifying
    assign wants_switch = (addressing_input_in != slave_mode_reg);

    // Filter limit cut to the counter width on purpose
    assign qual_limit = QUAL_CNT_W'(QUAL_COUNT);
    assign qual_expired = (qual_cnt_reg >= qual_limit);

    // Timer held at zero outside filtering so a later start is clean
    assign timer_clear = !in_filter || level_changed || !wants_switch;

    // Lock is accepted only from the filtering state and only as a slave
    assign lock_request = in_filter && is_slave && channel_activate_in;

    // Lock wins over a switch falling in the same cycle
    assign switch_now = in_filter && !lock_request && qual_expired && wants_switch && !level_changed;

    // Stream polarity from the two data pins
    assign polarity_low = pins_select_low(data_in_0_in, data_in_1_in);

    // Timer restarts on any level change so short pulses never switch
    always_comb
    begin
        qual_cnt_next = qual_cnt_reg;
        if (timer_clear)
            qual_cnt_next = '0;
        else if (!qual_expired)
            qual_cnt_next = qual_cnt_reg + QUAL_CNT_W'(1);
    end

    // Sequencer: initial pick, qualified switching, then freeze
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_INIT:
                if (init_done_in)
                    state_next = ST_FILTER;
            ST_FILTER:
                if (lock_request)
                    state_next = ST_LOCKED;
            ST_LOCKED:
                state_next = ST_LOCKED;
            default:
                state_next = ST_INIT;
        endcase
    end

    // Slave mode: taken once at initialization, then only after qualification
    always_comb
    begin
        slave_mode_next = slave_mode_reg;
        if (in_init && init_done_in)
            slave_mode_next = addressing_input_in;
        else if (switch_now)
            slave_mode_next = addressing_input_in;
    end

    // Outputs assembled from next state so they leave straight from flops
    always_comb
    begin
        status_next.logic_mode = is_slave ? slave_mode_next : 1'b1;
        status_next.stream_low_active = is_slave ? 1'b0 : polarity_low;
        status_next.locked = (state_next == ST_LOCKED);
    end

    // Sequencer flop; reset is the only exit from the locked state
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_INIT;
        end
        else if (clk_en_in)
        begin
            state_reg <= state_next;
        end
    end

    // Qualification timer flop
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            qual_cnt_reg <= '0;
        end
        else if (clk_en_in)
        begin
            qual_cnt_reg <= qual_cnt_next;
        end
    end

    // Previous level; only enabled edges count as samples
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            last_level_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            last_level_reg <= addressing_input_in;
        end
    end

    // Slave mode flop, current mode until initialization picks one
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            slave_mode_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            slave_mode_reg <= slave_mode_next;
        end
    end

    // Output flops; low clock enable freezes what is shown
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            status_reg <= '0;
        end
        else if (clk_en_in)
        begin
            status_reg <= status_next;
        end
    end

    // Status leaves straight from the output flops
    assign status_out = status_reg;
endmodule

/* File: addr_mode_monitor.sv */
// Checker of the addressing input mode selector
`timescale 1ns/1ps
module addr_mode_monitor
    import addr_mode_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic addressing_input_in,
    input wire logic data_in_0_in,
    input wire logic data_in_1_in,
    input wire role_t role_in,
    input wire logic channel_activate_in,
    input wire mode_status_t status_out
);
    // Low at the release edge, when the design flops still sit in reset
    logic live_reg;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            live_reg <= 1'h0;
        else
            live_reg <= 1'h1;
    end
    // Non-slave roles skip the filter
    wire logic slv = (role_in == ROLE_SLAVE);
    wire logic ms = live_reg && clk_en_in && !slv;
    wire logic eq = (data_in_0_in == data_in_1_in);
    wire logic lk = status_out.locked;
    wire logic mode = status_out.logic_mode;
    wire logic pol = status_out.stream_low_active;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_role_logic: assert property (ms |=> mode) else $error("logic mode not forced");
    a_pol_select: assert property (ms |=> pol == $past(eq)) else $error("stream polarity wrong");
    a_lock_hold: assert property (lk |=> lk) else $error("lock released");
    a_mode_frozen: assert property (lk && !ms |=> $stable(mode)) else $error("mode moved while locked");
    a_lock_cause: assert property ($rose(lk) |-> $past(channel_activate_in) && $past(slv)) else $error("lock without activation");
    a_change_restarts: assert property (live_reg && clk_en_in && $past(clk_en_in) && slv && $past(slv) && !lk
        && addressing_input_in != $past(addressing_input_in) |=> $stable(mode)) else $error("switch on changing input");
    cover property (lk);
    cover property (ms && !pol);
    cover property ($fell(mode));
    cover property ($rose(mode) && slv);
endmodule
bind addr_mode_select addr_mode_monitor mon (.*);

/* File: addr_src.sv */
// Source model on the addressing input
`timescale 1ns/1ps
module addr_src (input wire logic clk_sys_in, input wire logic lvl_in, output logic line_out);
    initial line_out = 1;
    always @(posedge clk_sys_in) line_out <= lvl_in;
endmodule

/* File: tb.sv */
// Testbench of the addressing input mode selector
`timescale 1ns/1ps
module tb;
    import addr_mode_pkg::*;
    logic clk_sys_in = 0, rst_n_in = 0, clk_en_in = 1, addressing_input_in, data_in_0_in = 0, data_in_1_in = 0;
    logic init_done_in = 0, channel_activate_in = 0, lvl = 1;
    role_t role_in = ROLE_SLAVE;
    mode_status_t status_out;
    int miscompares = 0, n_tests = 0;
    addr_mode_select #(.QUAL_COUNT(16)) DUT (.*);
    addr_src src (.clk_sys_in, .lvl_in(lvl), .line_out(addressing_input_in));
    initial forever #2 clk_sys_in = ~clk_sys_in;
    // Drive, wait, look 1 ns late
    task automatic step(input logic v, a, input int n, input mode_status_t e);
        @(posedge clk_sys_in) {lvl, channel_activate_in} <= {v, a};
        repeat (n) @(posedge clk_sys_in);
        #1 n_tests++;
        if (status_out !== e) begin miscompares++; $display("CHECK FAILED %0t %b", $time, status_out); end
    endtask
    task automatic report_and_stop();
        $display("%0d checks, %0d mismatches", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic slave_modes();
        step(1, 0, 2, 3'b100);
        step(0, 0, 12, 3'b100); step(1, 0, 2, 3'b100); step(0, 0, 12, 3'b100);
        step(0, 0, 14, 3'b000);
        step(1, 0, 14, 3'b000);
        step(1, 0, 10, 3'b100);
        step(1, 1, 1, 3'b101);
        step(0, 0, 30, 3'b101);
    endtask
    task automatic master_pol();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_in) {data_in_1_in, data_in_0_in} <= 2'(i);
            step(i[0] ~^ i[1], 0, 3, {1'b1, i[0] ~^ i[1], 1'b0});
        end
    endtask
    task automatic other_roles();
        @(posedge clk_sys_in);
        role_in <= ROLE_REPEATER;
        {data_in_1_in, data_in_0_in} <= 2'h1;
        step(1'h0, 1'h1, 3, 3'h4);
        @(posedge clk_sys_in);
        role_in <= ROLE_MONITOR;
        {clk_en_in, data_in_0_in} <= 2'h0;
        step(1'h1, 1'h0, 3, 3'h4);
        @(posedge clk_sys_in) clk_en_in <= 1'h1;
        step(1'h1, 1'h0, 3, 3'h6);
    endtask
    initial begin #2000 miscompares++; report_and_stop(); end
    initial begin
        repeat (16) @(posedge clk_sys_in);
        {rst_n_in, init_done_in} <= 2'b11;
        slave_modes();
        @(posedge clk_sys_in) rst_n_in <= 0;
        role_in <= ROLE_MASTER;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1;
        master_pol();
        other_roles();
        report_and_stop();
    end
endmodule
